//--- ee_pkg.sv
// Shared constants and types for the two-wire memory target.
`default_nettype none
package ee_pkg;

    // Device address byte layout.
    localparam logic [3:0] DEV_TYPE_CODE = 4'ha;     // Fixed one-zero type pattern.
    localparam int         DEV_TYPE_LSB  = 4;        // Lowest bit of the type pattern.
    localparam int         DEV_SEL_LSB   = 1;        // Lowest chip-select bit.
    localparam int         DEV_RW_BIT    = 0;        // Operation select bit, one reads.
    localparam logic [2:0] MODULE_SEL    = 3'h0;     // Select bits of the module variant.

    // Array and page geometry.
    localparam int         ADDR_W        = 12;       // Word-address bits in use.
    localparam int         HI_ADDR_BITS  = 4;        // Bits kept from the first address byte.
    localparam int         PAGE_W        = 5;        // In-page address bits.
    localparam int         PAGE_BYTES    = 32;       // Bytes in one page.
    localparam int         MEM_BYTES     = 4096;     // Bytes in the array.

    // Bit slots of one byte transfer.
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;     // Slot of the eighth bit.
    localparam logic [3:0] ACK_SLOT      = 4'h8;     // Slot of the ninth clock pulse.

    // Positions of the synchronised pins in one vector.
    localparam int         PIN_SCL       = 6;        // Serial clock.
    localparam int         PIN_SDA       = 5;        // Serial data.
    localparam int         PIN_CS2       = 4;        // Chip-select bit two.
    localparam int         PIN_CS1       = 3;        // Chip-select bit one.
    localparam int         PIN_CS0       = 2;        // Chip-select bit zero.
    localparam int         PIN_WP        = 1;        // Write protect.
    localparam int         PIN_MOD       = 0;        // Module variant strap.
    localparam int         PIN_N         = 7;        // Number of pins.
    localparam logic [6:0] PIN_RESET     = 7'h60;    // Idle bus reads high.

    // Self-timed programming duration.
    localparam int         PROG_TIME_US  = 5000;     // Longest programming time in us.
    localparam int         CLK_SYS_MHZ   = 50;       // System clock rate in MHz.
    localparam int         PROG_CYCLES_DFLT = PROG_TIME_US * CLK_SYS_MHZ;

    // Protocol states.
    typedef enum logic [2:0] {
        EE_IDLE,
        EE_DEV,
        EE_AHI,
        EE_ALO,
        EE_WR,
        EE_RD
    } ee_state_t;

endpackage
`default_nettype wire

//--- ee_two_wire_target.sv
// Operation
// - Programming time counts from stop to done.
// - Device address byte follows every start.
// - Top four bits must match type.
// - Next three bits match chip-select pins.
// - Floating chip-select pins count as low.
// - Module variant needs select bits zero.
// - Last address bit: one read, zero write.
// - Match acknowledges low, else back to standby.
// - Write protect high blocks array changes.
// - Two address bytes then data, all acknowledged.
// - Stop after data starts timed programming.
// - No response while programming runs.
// - Page write buffers up to 32 bytes.
// - Page write increments only lower five address bits.
// - Polling acknowledged only after programming ends.
// - Address counter persists, last plus one.
// - Read counter wraps end to start.
// - Current read sends byte at counter.
// - Controller acknowledge continues sequential read.
// - Eight-bit groups, ninth pulse acknowledges.
// - Data edges with clock high frame transfers.
// - Standby at power-up and after stop.

`timescale 1ns/1ns
`default_nettype none

module ee_two_wire_target
    import ee_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_CYCLES_DFLT
) (
    // System clock and reset.
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Sampling clock of the link logic.
    input  wire logic clk_link,
    // Serial bus pins, data is open drain.
    input  wire logic scl_in,
    input  wire logic sda_in,
    output var  logic sda_out,
    output var  logic sda_oe,
    // Straps and protection.
    input  wire logic chip_select_bit_two,
    input  wire logic chip_select_bit_one,
    input  wire logic chip_select_bit_zero,
    input  wire logic write_protect,
    input  wire logic module_variant,
    // Status.
    output var  logic standby,
    output var  logic prog_busy
);

    localparam int CNT_W = $clog2(PROG_CYCLES + 1);

    // State of the link-facing logic.
    typedef struct packed {
        logic [PIN_N-1:0]                pin_m1;   // First synchroniser stage.
        logic [PIN_N-1:0]                pin_m2;   // Second synchroniser stage.
        logic [PIN_N-1:0]                pin_m3;   // Third synchroniser stage.
        logic [PIN_N-1:0]                pin_f;    // Filtered pin levels.
        ee_state_t                       state;    // Protocol state.
        logic [3:0]                      cnt;      // Bit slot within the byte.
        logic [7:0]                      shreg;    // Receive or transmit shift.
        logic                            rw;       // Operation select of this access.
        logic                            ack_ok;   // This byte is acknowledged.
        logic                            mack;     // Controller acknowledged a read byte.
        logic [HI_ADDR_BITS-1:0]         addr_hi;  // Upper address part in flight.
        logic [ADDR_W-1:0]               addr;     // Persistent address counter.
        logic [PAGE_BYTES-1:0][7:0]      pbuf;     // Page write buffer.
        logic [PAGE_BYTES-1:0]           pmask;    // Bytes held in the buffer.
        logic                            oe;       // Data pin pulled low.
        logic                            busy;     // Programming in progress.
        logic                            req_tgl;  // Toggles to start programming.
        logic                            done_s1;  // Done toggle, first stage.
        logic                            done_s2;  // Done toggle, second stage.
        logic                            done_s3;  // Done toggle, edge reference.
        logic                            stby;     // Standby indication.
    } ee_link_t;

    // State of the system-clock timer.
    typedef struct packed {
        logic             req_s1;    // Request toggle, first stage.
        logic             req_s2;    // Request toggle, second stage.
        logic             req_s3;    // Request toggle, edge reference.
        logic             busy;      // Timer running.
        logic [CNT_W-1:0] cnt;       // Elapsed cycles.
        logic             done_tgl;  // Toggles when programming ends.
    } ee_sys_t;

    ee_link_t          ls_q;       // Link state.
    ee_link_t          ls_d;       // Next link state.
    ee_sys_t           ss_q;       // Timer state.
    ee_sys_t           ss_d;       // Next timer state.

    logic              rl_m1;      // Link reset, first stage.
    logic              rl_m2;      // Link reset, usable.
    logic [7:0]        mem [0:MEM_BYTES-1];  // Nonvolatile array, kept without reset.
    logic [7:0]        mem_rd;     // Byte at the address counter.

    logic              commit;     // Copy the page buffer into the array.
    logic [PIN_N-1:0]  pins_raw;   // Pins gathered for synchronising.
    logic              scl_rise;   // Filtered clock rose.
    logic              scl_fall;   // Filtered clock fell.
    logic              start_det;  // Start condition seen.
    logic              stop_det;   // Stop condition seen.
    logic              dev_match;  // Device address byte selects this device.
    logic [2:0]        sel_want;   // Expected select bits.

    // Pin vector and array read port.
    assign pins_raw = {scl_in, sda_in, chip_select_bit_two, chip_select_bit_one,
                       chip_select_bit_zero, write_protect, module_variant};
    assign mem_rd   = mem[ls_q.addr];

    // Carries the system reset into the link domain.
    // Reset-free stages; the link leaves reset two edges late.
    always_ff @(posedge clk_link) begin
        rl_m1 <= rst_n;
        rl_m2 <= rl_m1;
    end

    // Next value of the link logic.
    always_comb begin
        ls_d      = ls_q;
        commit    = 1'b0;
        // Three stages; a level counts once stages two and three agree.
        ls_d.pin_m1 = pins_raw;
        ls_d.pin_m2 = ls_q.pin_m1;
        ls_d.pin_m3 = ls_q.pin_m2;

        for (int i = 0; i < PIN_N; i++) begin
            if (ls_q.pin_m2[i] == ls_q.pin_m3[i]) begin
                ls_d.pin_f[i] = ls_q.pin_m3[i];
            end
        end

        // Edge and frame detection on filtered levels.
        scl_rise  = !ls_q.pin_f[PIN_SCL] && ls_d.pin_f[PIN_SCL];
        scl_fall  = ls_q.pin_f[PIN_SCL] && !ls_d.pin_f[PIN_SCL];
        start_det = ls_q.pin_f[PIN_SCL] && ls_d.pin_f[PIN_SCL]
                    && ls_q.pin_f[PIN_SDA] && !ls_d.pin_f[PIN_SDA];
        stop_det  = ls_q.pin_f[PIN_SCL] && ls_d.pin_f[PIN_SCL]
                    && !ls_q.pin_f[PIN_SDA] && ls_d.pin_f[PIN_SDA];

        // Address compare; an open select pin is seen as a low level.
        sel_want  = ls_q.pin_f[PIN_MOD] ? MODULE_SEL
                    : {ls_q.pin_f[PIN_CS2], ls_q.pin_f[PIN_CS1],
                       ls_q.pin_f[PIN_CS0]};
        dev_match = (ls_q.shreg[7:DEV_TYPE_LSB] == DEV_TYPE_CODE)
                    && (ls_q.shreg[DEV_TYPE_LSB-1:DEV_SEL_LSB] == sel_want);

        // Programming done arrives as a toggle from the timer.
        ls_d.done_s1 = ss_q.done_tgl;
        ls_d.done_s2 = ls_q.done_s1;
        ls_d.done_s3 = ls_q.done_s2;
        if (ls_q.done_s2 != ls_q.done_s3) begin
            ls_d.busy = 1'b0;
        end

        if (start_det) begin
            // Every start opens a device address byte; unsent page data is dropped.
            ls_d.state = EE_DEV;
            // One below zero: the fall after a start opens the first bit.
            ls_d.cnt   = '1;
            ls_d.oe    = 1'b0;
            ls_d.pmask = '0;
        end else if (stop_det) begin
            // A stop after buffered data starts programming unless protected.
            if ((ls_q.pmask != '0) && !ls_q.pin_f[PIN_WP]) begin
                commit       = 1'b1;
                ls_d.busy    = 1'b1;
                ls_d.req_tgl = !ls_q.req_tgl;
            end
            ls_d.state = EE_IDLE;
            ls_d.pmask = '0;
            ls_d.oe    = 1'b0;
        end else if (ls_q.state != EE_IDLE) begin
            // Clock high: take a data bit, or the controller's answer to a read byte.
            if (scl_rise) begin
                if (ls_q.cnt == ACK_SLOT) begin
                    ls_d.mack = !ls_q.pin_f[PIN_SDA];
                end else if (ls_q.state != EE_RD) begin
                    ls_d.shreg = {ls_q.shreg[6:0], ls_q.pin_f[PIN_SDA]};
                end
            end
            // Clock low: the pin may change, so move to the next slot.
            if (scl_fall) begin
                if (ls_q.cnt == LAST_DATA_BIT) begin
                    // Eighth bit done: decide the acknowledge of the ninth pulse.
                    ls_d.cnt    = ACK_SLOT;
                    ls_d.ack_ok = 1'b1;
                    ls_d.oe     = 1'b1;
                    unique case (ls_q.state)
                        EE_DEV: begin
                            ls_d.rw = ls_q.shreg[DEV_RW_BIT];
                            if (!dev_match || ls_q.busy) begin
                                ls_d.state  = EE_IDLE;
                                ls_d.ack_ok = 1'b0;
                                ls_d.oe     = 1'b0;
                            end
                        end
                        EE_AHI: begin
                            // Unused upper bits of the first byte are dropped.
                            ls_d.addr_hi = ls_q.shreg[HI_ADDR_BITS-1:0];
                        end
                        EE_ALO: begin
                            ls_d.addr = {ls_q.addr_hi, ls_q.shreg};
                        end
                        EE_WR: begin
                            // Buffer the byte; only the in-page bits count on.
                            ls_d.pbuf[ls_q.addr[PAGE_W-1:0]]  = ls_q.shreg;
                            ls_d.pmask[ls_q.addr[PAGE_W-1:0]] = 1'b1;
                            ls_d.addr[PAGE_W-1:0] = ls_q.addr[PAGE_W-1:0]
                                                    + {{(PAGE_W-1){1'b0}}, 1'b1};
                        end
                        EE_RD: begin
                            // The controller answers in this slot.
                            ls_d.oe = 1'b0;
                        end
                        EE_IDLE: begin
                            ls_d.oe = 1'b0;
                        end
                    endcase
                end else if (ls_q.cnt == ACK_SLOT) begin
                    // Ninth pulse done: release and choose the next byte.
                    ls_d.cnt = 4'h0;
                    ls_d.oe  = 1'b0;
                    unique case (ls_q.state)
                        EE_DEV: ls_d.state = ls_q.rw ? EE_RD : EE_AHI;
                        EE_AHI: ls_d.state = EE_ALO;
                        EE_ALO: ls_d.state = EE_WR;
                        EE_WR:  ls_d.state = EE_WR;
                        EE_RD:  ls_d.state = ls_q.mack ? EE_RD : EE_IDLE;
                        EE_IDLE: ls_d.state = EE_IDLE;
                    endcase
                    if ((ls_q.state == EE_DEV && ls_q.rw)
                        || (ls_q.state == EE_RD && ls_q.mack)) begin
                        // Fetch the byte at the counter and move the counter on.
                        ls_d.shreg = mem_rd;
                        ls_d.oe    = !mem_rd[7];
                        ls_d.addr  = ls_q.addr + {{(ADDR_W-1){1'b0}}, 1'b1};
                    end
                end else begin
                    // Ordinary bit slot; a read drives the next bit.
                    ls_d.cnt = ls_q.cnt + 4'h1;
                    if (ls_q.state == EE_RD) begin
                        ls_d.shreg = {ls_q.shreg[6:0], 1'b0};
                        ls_d.oe    = !ls_q.shreg[6];
                    end
                end
            end
        end

        // Standby once the bus is idle and programming has finished.
        ls_d.stby = (ls_d.state == EE_IDLE) && !ls_d.busy;
    end

    // Registers the link state; reset also clears the counter and buffer.
    always_ff @(posedge clk_link) begin
        if (!rl_m2) begin
            ls_q.pin_m1  <= PIN_RESET;
            ls_q.pin_m2  <= PIN_RESET;
            ls_q.pin_m3  <= PIN_RESET;
            ls_q.pin_f   <= PIN_RESET;

            ls_q.state   <= EE_IDLE;
            ls_q.cnt     <= 4'h0;
            ls_q.shreg   <= 8'h00;
            ls_q.rw      <= 1'b0;
            ls_q.ack_ok  <= 1'b0;
            ls_q.mack    <= 1'b0;
            ls_q.addr_hi <= '0;
            ls_q.addr    <= '0;
            ls_q.pbuf    <= '0;
            ls_q.pmask   <= '0;
            ls_q.oe      <= 1'b0;

            ls_q.busy    <= 1'b0;
            ls_q.req_tgl <= 1'b0;
            ls_q.done_s1 <= 1'b0;
            ls_q.done_s2 <= 1'b0;
            ls_q.done_s3 <= 1'b0;
            ls_q.stby    <= 1'b1;
        end else begin
            ls_q <= ls_d;
        end
    end

    // Array update at the start of programming; the page row stays fixed.
    always_ff @(posedge clk_link) begin
        if (commit) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (ls_q.pmask[i]) begin
                    mem[{ls_q.addr[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= ls_q.pbuf[i];
                end
            end
        end
    end

    // Next value of the programming timer.
    always_comb begin
        ss_d        = ss_q;
        ss_d.req_s1 = ls_q.req_tgl;
        ss_d.req_s2 = ss_q.req_s1;
        ss_d.req_s3 = ss_q.req_s2;

        // The request crosses as one toggle bit, so no word can tear.
        if (ss_q.req_s2 != ss_q.req_s3) begin
            // New request starts the count from the stop.
            ss_d.busy = 1'b1;
            ss_d.cnt  = '0;
        end else if (ss_q.busy) begin
            if (ss_q.cnt == CNT_W'(PROG_CYCLES - 1)) begin
                // Programming finished: release the bus logic.
                ss_d.busy     = 1'b0;
                ss_d.done_tgl = !ss_q.done_tgl;
            end else begin
                ss_d.cnt = ss_q.cnt + CNT_W'(1);
            end
        end
    end

    // Registers the timer state.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ss_q <= '0;
        end else begin
            ss_q <= ss_d;
        end
    end

    // Outputs straight from flip-flops; the data level is a constant low.
    assign sda_out   = 1'b0;
    assign sda_oe    = ls_q.oe;
    assign standby   = ls_q.stby;
    assign prog_busy = ss_q.busy;

endmodule

`default_nettype wire

//--- ee_target_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// Watches the target's pins and status for protocol slips.
module ee_target_monitor #(
    parameter int PROG_CYCLES = 3000
) (
    // Clocks and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_link,
    // Bus pins.
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // Status.
    input wire logic standby,
    input wire logic prog_busy
);
    int busy_cnt_q;    // Cycles that the programming timer has run so far.

    // Counts system cycles while programming is busy.
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !prog_busy) begin
            busy_cnt_q <= 0;
        end else begin
            busy_cnt_q <= busy_cnt_q + 1;
        end
    end

    // The bus rests with both lines released.
    sequence s_bus_idle;
        scl_in && sda_in;
    endsequence
    // A driven low holds through at least part of the slot.
    sequence s_ack_slot;
        sda_oe [*4];
    endsequence

    a_drive_low: assert property (
        @(posedge clk_link) disable iff (!rst_n) sda_out == 1'b0) else $error("sda_out not low");
    a_busy_silent: assert property (
        @(posedge clk_link) disable iff (!rst_n) prog_busy |-> !sda_oe) else $error("drive while busy");
    a_idle_quiet: assert property (
        @(posedge clk_link) disable iff (!rst_n) standby |-> !sda_oe) else $error("drive in standby");
    a_ack_holds: assert property (
        @(posedge clk_link) disable iff (!rst_n) $rose(sda_oe) |-> s_ack_slot) else $error("short drive");
    a_edge_scl_low: assert property (
        @(posedge clk_link) disable iff (!rst_n) $changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
        else $error("data moved with clock high");
    a_prog_after_stop: assert property (
        @(posedge clk_sys) disable iff (!rst_n) $rose(prog_busy) |-> s_bus_idle)
        else $error("programming began without stop");
    a_busy_no_standby: assert property (
        @(posedge clk_sys) disable iff (!rst_n) prog_busy [*8] |-> !standby)
        else $error("standby while programming");
    a_prog_length: assert property (
        @(posedge clk_sys) disable iff (!rst_n) $fell(prog_busy) |->
        (busy_cnt_q >= PROG_CYCLES - 1) && (busy_cnt_q <= PROG_CYCLES + 1))
        else $error("programming time wrong");
endmodule

bind ee_two_wire_target ee_target_monitor #(.PROG_CYCLES(PROG_CYCLES)) ee_target_monitor_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_link(clk_link), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .standby(standby), .prog_busy(prog_busy));
`default_nettype wire

//--- ee_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
// Behavioural bus controller; the serial clock stands high between frames.
module ee_ctrl_model (
    // Link clock.
    input  wire logic clk_link,
    // Resolved data wire and the controller's drives.
    input  wire logic sda_line,
    output var  logic scl_drv,
    output var  logic sda_drv
);
    // Both lines start released.
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    // Waits a number of link clock edges.
    task automatic tick(input int n);
        repeat (n) @(posedge clk_link);
    endtask
    // One slot: data set while the clock is low, read in the high phase, then c.
    task automatic slot(input logic b, input logic c, input int n, output logic got);
        scl_drv <= 1'b0;
        tick(4);
        sda_drv <= b;
        tick(5);
        scl_drv <= 1'b1;
        tick(4);
        got = sda_line;
        tick(5);
        sda_drv <= c;
        tick(n);
    endtask
    // Start or repeated start: data falls with the clock high.
    task automatic bus_start();
        logic g;
        slot(1'b1, 1'b0, 9, g);
    endtask
    // Stop: data rises with the clock high.
    task automatic bus_stop();
        logic g;
        slot(1'b0, 1'b1, 9, g);
    endtask
    // Sends a byte most significant bit first and returns the acknowledge.
    task automatic bus_wr(input logic [7:0] d, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) slot(d[i], d[i], 0, g);
        slot(1'b1, 1'b1, 0, g);
        ack = !g;
    endtask
    // Receives a byte, then drives low to continue or leaves high to end.
    task automatic bus_rd(input logic more, output logic [7:0] d);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            slot(1'b1, 1'b1, 0, g);
            d[i] = g;
        end
        slot(!more, !more, 0, g);
    endtask
endmodule
`default_nettype wire

//--- test_ee_two_wire_target.sv
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the two-wire memory target.
module test_ee_two_wire_target;
    import ee_pkg::*;
    localparam int PROG_N = 3000;      // Shortened programming time.
    localparam int LIMIT  = 99000;     // Cycle ceiling of the whole run.
    logic       clk_sys;
    logic       clk_link;
    logic       rst_n;
    logic [2:0] cs;                    // Strap levels, 0 stands for a floating pin.
    logic       wp;
    logic       modv;
    logic       sda_oe;
    logic       sda_out;
    logic       standby;
    logic       prog_busy;
    logic       scl_drv;
    logic       sda_drv;
    wire logic  sda_line = sda_drv & ~sda_oe;    // Pulled-up wire of both parties.
    int         n_mismatch = 0;
    int         checks = 0;
    int         cyc = 0;

    ee_two_wire_target #(.PROG_CYCLES(PROG_N)) ee_two_wire_target_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_link(clk_link), .scl_in(scl_drv),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .chip_select_bit_two(cs[2]), .chip_select_bit_one(cs[1]),
        .chip_select_bit_zero(cs[0]), .write_protect(wp), .module_variant(modv),
        .standby(standby), .prog_busy(prog_busy));
    ee_ctrl_model ee_ctrl_model_i (.clk_link(clk_link), .sda_line(sda_line),
        .scl_drv(scl_drv), .sda_drv(sda_drv));

    // System clock, 20 ns.
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Link clock, 125 ns, offset from the system clock.
    initial begin
        clk_link = 1'b0;
        #7;
        forever begin
            #62 clk_link = ~clk_link;
            #63 clk_link = ~clk_link;
        end
    end
    // Cuts a hung run short.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_mismatch = n_mismatch + 1;
            end_sim();
        end
    end

    // Compares one bit.
    task automatic chk_bit(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask
    // Compares one byte.
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Start and device address byte.
    task automatic dev(input logic [3:0] ty, input logic [2:0] sel, input logic rd,
                       output logic ack);
        ee_ctrl_model_i.bus_start();
        ee_ctrl_model_i.bus_wr({ty, sel, rd}, ack);
    endtask
    // Waits, bounded, until programming is over and the target rests.
    task automatic wait_ready();
        int k = 0;
        while ((prog_busy !== 1'b0 || standby !== 1'b1) && k < 5000) begin
            @(posedge clk_sys);
            k++;
        end
        chk_bit("standby", 1'b1, standby);
    endtask
    // Addresses the target once and closes with a stop.
    task automatic sel_try(input logic [3:0] ty, input logic [2:0] sel, input logic exp);
        logic ack;
        dev(ty, sel, 1'b0, ack);
        ee_ctrl_model_i.bus_stop();
        chk_bit("select", exp, ack);
    endtask
    // Writes n bytes counting up from base; busy says if programming must follow.
    task automatic do_write(input logic [15:0] a, input int n, input logic [7:0] base,
                            input logic busy);
        logic ack;
        dev(DEV_TYPE_CODE, 3'h5, 1'b0, ack);
        ee_ctrl_model_i.bus_wr(a[15:8], ack);
        chk_bit("addr hi ack", 1'b1, ack);
        ee_ctrl_model_i.bus_wr(a[7:0], ack);
        for (int i = 0; i < n; i++) begin
            ee_ctrl_model_i.bus_wr(base + 8'(i), ack);
            chk_bit("data ack", 1'b1, ack);
        end
        ee_ctrl_model_i.bus_stop();
        repeat (20) @(posedge clk_sys);
        chk_bit("busy after stop", busy, prog_busy);
        if (busy) begin
            sel_try(DEV_TYPE_CODE, 3'h5, 1'b0);
        end
        wait_ready();
        sel_try(DEV_TYPE_CODE, 3'h5, 1'b1);
    endtask
    // Reads n bytes (one or two), loading the address first unless cur is set.
    task automatic do_read(input logic cur, input logic [15:0] a, input int n,
                           input logic [15:0] exp);
        logic       ack;
        logic [7:0] d;
        if (!cur) begin
            dev(DEV_TYPE_CODE, 3'h5, 1'b0, ack);
            ee_ctrl_model_i.bus_wr(a[15:8], ack);
            ee_ctrl_model_i.bus_wr(a[7:0], ack);
        end
        dev(DEV_TYPE_CODE, 3'h5, 1'b1, ack);
        chk_bit("read select", 1'b1, ack);
        for (int i = 0; i < n; i++) begin
            ee_ctrl_model_i.bus_rd(i < n - 1, d);
            chk_byte("read data", (i == 0) ? exp[15:8] : exp[7:0], d);
        end
        ee_ctrl_model_i.bus_stop();
        wait_ready();
    endtask

    // Device selection by type, straps, floating straps and the module variant.
    task automatic t_select();
        for (int s = 0; s < 8; s++) sel_try(DEV_TYPE_CODE, 3'(s), s == 5);
        sel_try(4'hb, 3'h5, 1'b0);
        modv <= 1'b1;
        sel_try(DEV_TYPE_CODE, MODULE_SEL, 1'b1);
        sel_try(DEV_TYPE_CODE, 3'h5, 1'b0);
        modv <= 1'b0;
        cs <= 3'h0;
        sel_try(DEV_TYPE_CODE, 3'h0, 1'b1);
        cs <= 3'h5;
        $display("test select done");
    endtask
    // Page write with in-page wrap, then writes at both array ends.
    task automatic t_write();
        do_write(16'hf71e, 4, 8'h10, 1'b1);
        do_write(16'h0fff, 1, 8'h40, 1'b1);
        do_write(16'h0000, 1, 8'h41, 1'b1);
        $display("test write done");
    endtask
    // Random, wrapped, current-address and array-end reads.
    task automatic t_read();
        do_read(1'b0, 16'h071e, 2, 16'h1011);
        do_read(1'b0, 16'h0700, 1, 16'h1200);
        do_read(1'b1, 16'h0000, 1, 16'h1300);
        do_read(1'b0, 16'h0fff, 2, 16'h4041);
        $display("test read done");
    endtask
    // A protected write is acknowledged but leaves the array alone.
    task automatic t_protect();
        wp <= 1'b1;
        do_write(16'h0000, 1, 8'h77, 1'b0);
        wp <= 1'b0;
        do_read(1'b0, 16'h0000, 1, 16'h4100);
        $display("test protect done");
    endtask

    // Main sequence.
    initial begin
        rst_n = 1'b0;
        cs = 3'h5;
        wp = 1'b0;
        modv = 1'b0;
        repeat (8) @(posedge clk_link);
        @(posedge clk_sys) rst_n <= 1'b1;
        repeat (10) @(posedge clk_link);
        chk_bit("standby at reset", 1'b1, standby);
        t_select();
        t_write();
        t_read();
        t_protect();
        end_sim();
    end
endmodule
`default_nettype wire
